// file: core/sbmi_port.sv
`timescale 1ns/1ps
`default_nettype none

module sbmi_port #(
    parameter int unsigned TMO_MAX_CYC = sbmi_pkg::TMO_MAX_CYC
) (
    input  wire logic                       mclk_i,
    input  wire logic                       rst_i,
    input  wire logic                       req_i,
    input  wire logic                       we_i,
    input  wire logic                       io_i,
    input  wire logic                       byte_i,
    input  wire logic [sbmi_pkg::ADR_W-1:0] addr_i,
    input  wire logic [sbmi_pkg::DAT_W-1:0] wdata_i,
    input  wire logic                       cpu_reset_i,
    input  wire logic                       cfg_release_i,
    output logic                            done_o,
    output logic                            err_o,
    output logic      [sbmi_pkg::DAT_W-1:0] rdata_o,
    output logic      [sbmi_pkg::ADR_W-1:0] adr_o,
    output logic      [sbmi_pkg::DAT_W-1:0] dat_o,
    output logic                            dat_oe_o,
    input  wire logic [sbmi_pkg::DAT_W-1:0] dat_i,
    output logic                            mrdc_n_o,
    output logic                            mwtc_n_o,
    output logic                            iorc_n_o,
    output logic                            iowc_n_o,
    input  wire logic                       xack_n_i,
    output logic                            breq_n_o,
    input  wire logic                       bprn_n_i,
    input  wire logic                       busy_n_i,
    output logic                            busy_n_o,
    output logic                            busy_oe_o,
    input  wire logic                       cbrq_n_i,
    output logic                            init_n_o,
    input  wire logic                       tmr1_i,
    input  wire logic                       tmr3_i
);
    import sbmi_pkg::*;

    localparam int unsigned BK_W = $clog2(TMO_MAX_CYC + 1);

    sbmi_state_t            state;
    logic [SYNC_W-1:0]      pin_s;
    logic                   ack;
    logic                   prio;
    logic                   busy_other;
    logic                   cbrq;
    logic                   t1_d;
    logic                   t3_d;
    logic                   t1_rise;
    logic                   t3_rise;
    logic                   mode_rel;
    logic                   own;
    logic                   we_r;
    logic                   io_r;
    logic                   byte_r;
    logic                   odd_r;
    logic [1:0]             ws_cnt;
    logic [1:0]             yield_cnt;
    logic                   yield_now;
    logic                   start;
    logic                   tmo_run;
    logic                   armed;
    logic [BK_W-1:0]        bk_cnt;
    logic                   tmo_fire;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Foreign pins pass the three-stage synchroniser
    sbmi_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .pin_i   ({tmr3_i, tmr1_i, cbrq_n_i, busy_n_i, bprn_n_i, xack_n_i}),
        .lvl_o   (pin_s)
    );

    // Decoded pin levels and timer rising edges, active high
    assign ack        = ~pin_s[0];
    assign prio       = ~pin_s[1];
    assign busy_other = ~pin_s[2];
    assign cbrq       = ~pin_s[3];
    assign t1_rise    = pin_s[4] & ~t1_d;
    assign t3_rise    = pin_s[5] & ~t3_d;

    // Owner in hold mode leaves the bus once a lower master asks
    assign yield_now  = own & ~mode_rel & cbrq;
    assign start      = (state == ST_IDLE) & req_i & ~yield_now;

    // Timer 1 edge arms, next timer 3 edge fires; counter is a backstop
    assign tmo_fire   = tmo_run & ((armed & t3_rise) |
                        (bk_cnt == BK_W'(TMO_MAX_CYC - 1)));

    // Bus init follows power-on reset and the processor reset instruction
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            init_n_o <= 1'b0;
            busy_n_o <= 1'b1;
        end else begin
            init_n_o <= ~cpu_reset_i;
            busy_n_o <= 1'b0;
        end
    end

    // Timer edge history
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            t1_d <= 1'b0;
            t3_d <= 1'b0;
        end else begin
            t1_d <= pin_s[4];
            t3_d <= pin_s[5];
        end
    end

    // Access timeout, started at the request and stopped by acknowledge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_run <= 1'b0;
            armed   <= 1'b0;
            bk_cnt  <= '0;
        end else if (start) begin
            tmo_run <= 1'b1;
            armed   <= t1_rise;
            bk_cnt  <= '0;
        end else if (tmo_run && (tmo_fire || (state == ST_WAIT && ack))) begin
            tmo_run <= 1'b0;
        end else if (tmo_run) begin
            bk_cnt <= bk_cnt + 1'b1;
            if (t1_rise) begin
                armed <= 1'b1;
            end
        end
    end

    // Access sequencer: acquire, command, acknowledge, yield
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            own       <= 1'b0;
            busy_oe_o <= 1'b0;
            breq_n_o  <= 1'b1;
            mode_rel  <= 1'b0;
            we_r      <= 1'b0;
            io_r      <= 1'b0;
            byte_r    <= 1'b0;
            odd_r     <= 1'b0;
            ws_cnt    <= '0;
            yield_cnt <= '0;
            adr_o     <= '0;
            dat_o     <= '0;
            dat_oe_o  <= 1'b0;
            mrdc_n_o  <= 1'b1;
            mwtc_n_o  <= 1'b1;
            iorc_n_o  <= 1'b1;
            iowc_n_o  <= 1'b1;
            rdata_o   <= '0;
            done_o    <= 1'b0;
            err_o     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            err_o  <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (yield_now) begin
                        own       <= 1'b0;
                        busy_oe_o <= 1'b0;
                        breq_n_o  <= 1'b1;
                        yield_cnt <= YIELD_CYC;
                        state     <= ST_YIELD;
                    end else if (req_i) begin
                        mode_rel <= cfg_release_i;
                        ws_cnt   <= cfg_release_i ? REL_WS : 2'h0;
                        we_r     <= we_i;
                        io_r     <= io_i;
                        byte_r   <= byte_i;
                        odd_r    <= addr_i[0];
                        adr_o    <= addr_i;
                        if (!byte_i) begin
                            dat_o <= wdata_i;
                        end else if (addr_i[0]) begin
                            dat_o <= {8'h00, wdata_i[7:0]};
                        end else begin
                            dat_o <= {wdata_i[7:0], 8'h00};
                        end
                        breq_n_o <= 1'b0;
                        state    <= own ? ST_CMD : ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (tmo_fire) begin
                        err_o    <= 1'b1;
                        breq_n_o <= 1'b1;
                        state    <= ST_IDLE;
                    end else if (prio && !busy_other) begin
                        own       <= 1'b1;
                        busy_oe_o <= 1'b1;
                        state     <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (tmo_fire) begin
                        err_o     <= 1'b1;
                        own       <= 1'b0;
                        busy_oe_o <= 1'b0;
                        breq_n_o  <= 1'b1;
                        yield_cnt <= YIELD_CYC;
                        state     <= ST_YIELD;
                    end else if (ws_cnt != 2'h0) begin
                        dat_oe_o <= we_r;
                        ws_cnt   <= ws_cnt - 2'h1;
                    end else if (!ack) begin
                        dat_oe_o <= we_r;
                        mrdc_n_o <= ~(~io_r & ~we_r);
                        mwtc_n_o <= ~(~io_r & we_r);
                        iorc_n_o <= ~(io_r & ~we_r);
                        iowc_n_o <= ~(io_r & we_r);
                        state    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ack || tmo_fire) begin
                        mrdc_n_o <= 1'b1;
                        mwtc_n_o <= 1'b1;
                        iorc_n_o <= 1'b1;
                        iowc_n_o <= 1'b1;
                        dat_oe_o <= 1'b0;
                        done_o   <= ack;
                        err_o    <= ~ack;
                        if (ack && !byte_r) begin
                            rdata_o <= dat_i;
                        end else if (ack) begin
                            rdata_o <= {8'h00, odd_r ? dat_i[7:0] : dat_i[15:8]};
                        end
                        if (mode_rel || cbrq || !ack) begin
                            own       <= 1'b0;
                            busy_oe_o <= 1'b0;
                            breq_n_o  <= 1'b1;
                            yield_cnt <= YIELD_CYC;
                            state     <= ST_YIELD;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_YIELD: begin
                    if (yield_cnt == 2'h0) begin
                        state <= ST_IDLE;
                    end else begin
                        yield_cnt <= yield_cnt - 2'h1;
                    end
                end
            endcase
        end
    end

    property p_lane;
        done_o && byte_r && !odd_r |-> rdata_o[7:0] == $past(dat_i[15:8]);
    endproperty
    a_lane: assert property (p_lane) else $error("even byte not taken from upper lane");

    property p_addr;
        !mrdc_n_o || !mwtc_n_o || !iorc_n_o || !iowc_n_o |-> adr_o == $past(adr_o);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved during strobe");

    property p_init;
        cpu_reset_i |=> !init_n_o;
    endproperty
    a_init: assert property (p_init) else $error("init not asserted on reset instruction");

    property p_init_own;
        !cpu_reset_i |=> init_n_o;
    endproperty
    a_init_own: assert property (p_init_own) else $error("init driven without cause");

    property p_tmo;
        tmo_fire && (state != ST_IDLE) && !(state == ST_WAIT && ack) |=> err_o && !tmo_run;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout did not give bus error");

    property p_start;
        state == ST_IDLE && req_i && !yield_now |=> tmo_run && bk_cnt == '0;
    endproperty
    a_start: assert property (p_start) else $error("timeout not started at request");

    property p_phase;
        err_o |-> $past(armed && t3_rise) || $past(bk_cnt) == BK_W'(TMO_MAX_CYC - 1);
    endproperty
    a_phase: assert property (p_phase) else $error("timeout fired without timer phase");

    property p_prio;
        $rose(own) |-> $past(prio) && $past(state) == ST_ACQ;
    endproperty
    a_prio: assert property (p_prio) else $error("bus taken without priority grant");

    property p_rel;
        done_o && mode_rel |-> !own && !busy_oe_o;
    endproperty
    a_rel: assert property (p_rel) else $error("bus kept in release mode");

    property p_ws;
        state == ST_CMD && $past(state) != ST_CMD && mode_rel
            |-> (mrdc_n_o && mwtc_n_o && iorc_n_o && iowc_n_o) [*4];
    endproperty
    a_ws: assert property (p_ws) else $error("wait states missing in release mode");

    property p_hold;
        state == ST_IDLE && own && !mode_rel && !cbrq |=> own;
    endproperty
    a_hold: assert property (p_hold) else $error("bus dropped without request");

    property p_yield;
        $fell(own) |-> !own [*2];
    endproperty
    a_yield: assert property (p_yield) else $error("bus retaken too soon");

    property p_mode;
        state != ST_IDLE |=> $stable(mode_rel);
    endproperty
    a_mode: assert property (p_mode) else $error("mode changed during access");

    property p_stop;
        state == ST_WAIT && ack |=> !tmo_run && done_o;
    endproperty
    a_stop: assert property (p_stop) else $error("timeout still running after acknowledge");

    c_done:  cover property (done_o && !we_r);
    c_err:   cover property (err_o);
    c_yield: cover property (state == ST_IDLE && yield_now);
    c_rel:   cover property (done_o && mode_rel);

endmodule : sbmi_port

`default_nettype wire

// file: core/sbmi_pkg.sv
package sbmi_pkg;

    // Bus widths
    localparam int unsigned ADR_W       = 20;
    localparam int unsigned DAT_W       = 16;

    // Clock rate and access timeout backstop (longest time, rounds down)
    localparam int unsigned CLK_HZ      = 40_000_000;
    localparam int unsigned TMO_MAX_MS  = 3;
    localparam int unsigned TMO_MAX_CYC = CLK_HZ / 1000 * TMO_MAX_MS;

    // Extra wait states in release-every-cycle mode
    localparam logic [1:0]  REL_WS      = 2'h3;
    // Extra cycles spent off the bus after giving it up
    localparam logic [1:0]  YIELD_CYC   = 2'h1;

    // Synchroniser reset levels: {tmr3, tmr1, cbrq_n, busy_n, bprn_n, xack_n}
    localparam logic [5:0]  SYNC_RST    = 6'h0f;
    localparam int unsigned SYNC_W      = 6;

    // Access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQ,
        ST_CMD,
        ST_WAIT,
        ST_YIELD
    } sbmi_state_t;

endpackage : sbmi_pkg

// file: core/sbmi_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sbmi_sync #(
    parameter int unsigned       W       = 1,
    parameter logic [W-1:0]      RST_VAL = '0
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_i,
    input  wire logic [W-1:0]    pin_i,
    output logic      [W-1:0]    lvl_o
);

    // Three-stage capture per pin; level moves only when stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                s1  <= RST_VAL[i];
                s2  <= RST_VAL[i];
                s3  <= RST_VAL[i];
                lvl <= RST_VAL[i];
            end else begin
                s1 <= pin_i[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    lvl <= s3;
                end
            end
        end
        assign lvl_o[i] = lvl;
    end

endmodule : sbmi_sync

`default_nettype wire

// file: tb/sbmi_periph.sv
`timescale 1ns/1ps
`default_nettype none

module sbmi_periph (
    input  wire logic        mclk_i,
    input  wire logic [19:0] adr_i,
    input  wire logic [15:0] dat_i,
    input  wire logic [3:0]  cmd_n_i,
    input  wire logic        mute_i,
    input  wire logic [3:0]  dly_i,
    output logic             xack_n_o   = 1'b1,
    output logic      [15:0] dat_o      = 16'h0000,
    output logic      [19:0] seen_adr_o = 20'h00000,
    output logic      [3:0]  seen_cmd_o = 4'hf
);
    logic [15:0] mem [16];
    logic [3:0]  cnt = 4'h0;

    // Answers a command after dly_i cycles, holds ack until the strobe ends
    always @(posedge mclk_i) begin
        if (&cmd_n_i) begin
            cnt      <= 4'h0;
            xack_n_o <= 1'b1;
            dat_o    <= ~dat_o; // Released lines show no stale value
        end else if (xack_n_o && !mute_i) begin
            if (cnt == dly_i) begin
                xack_n_o   <= 1'b0;
                seen_adr_o <= adr_i;
                seen_cmd_o <= cmd_n_i;
                if (!cmd_n_i[1] || !cmd_n_i[3]) begin
                    mem[adr_i[4:1]] <= dat_i;
                end else begin
                    dat_o <= mem[adr_i[4:1]];
                end
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : sbmi_periph

`default_nettype wire

// file: tb/sbmi_port_test.sv
`timescale 1ns/1ps
`default_nettype none

module sbmi_port_test;
    import sbmi_pkg::*;
    localparam int unsigned TMO = 200;

    logic        mclk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, io = 1'b0, byte_acc = 1'b0;
    logic        cpu_reset = 1'b0, cfg_release = 1'b0, cbrq_n = 1'b1, tmr1 = 1'b0, tmr3 = 1'b0;
    logic        other_busy_n = 1'b1, mute = 1'b0;
    logic [3:0]  dly = 4'h0;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic        done, err, dat_oe, mrdc_n, mwtc_n, iorc_n, iowc_n, xack_n, breq_n;
    logic        busy_n_out, busy_oe, init_n;
    logic [15:0] rdata, dat, dat_in;
    logic [19:0] adr, seen_adr;
    logic [3:0]  seen_cmd;
    wire  [3:0]  cmd_n = {iowc_n, iorc_n, mwtc_n, mrdc_n};
    // Open-drain busy wire seen by every party
    wire         busy_w = (busy_oe ? busy_n_out : 1'b1) & other_busy_n;
    int          n_errors = 0, n_checks = 0, n_done = 0, n_err = 0, lat_hold = 0;

    always #12.5 mclk_i = ~mclk_i;

    sbmi_port #(.TMO_MAX_CYC(TMO)) sbmi_port_i (
        .mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .we_i(we), .io_i(io), .byte_i(byte_acc),
        .addr_i(addr), .wdata_i(wdata), .cpu_reset_i(cpu_reset), .cfg_release_i(cfg_release),
        .done_o(done), .err_o(err), .rdata_o(rdata), .adr_o(adr), .dat_o(dat), .dat_oe_o(dat_oe),
        .dat_i(dat_in), .mrdc_n_o(mrdc_n), .mwtc_n_o(mwtc_n), .iorc_n_o(iorc_n), .iowc_n_o(iowc_n),
        .xack_n_i(xack_n), .breq_n_o(breq_n), .bprn_n_i(1'b0), .busy_n_i(busy_w),
        .busy_n_o(busy_n_out), .busy_oe_o(busy_oe), .cbrq_n_i(cbrq_n), .init_n_o(init_n),
        .tmr1_i(tmr1), .tmr3_i(tmr3));

    sbmi_periph sbmi_periph_i (
        .mclk_i(mclk_i), .adr_i(adr), .dat_i(dat), .cmd_n_i(cmd_n), .mute_i(mute), .dly_i(dly),
        .xack_n_o(xack_n), .dat_o(dat_in), .seen_adr_o(seen_adr), .seen_cmd_o(seen_cmd));

    // Counts completion and error pulses
    always @(posedge mclk_i) begin
        if (done === 1'b1) n_done++;
        if (err === 1'b1) n_err++;
    end

    // Value comparison
    task automatic chk_val(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc

    // One access, k = {write, io, byte}; lat counts edges from take to strobe
    task automatic acc(input logic [2:0] k, input logic [19:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic fin, output int lat);
        logic oe;
        cyc(4);
        req <= 1'b1;
        {we, io, byte_acc} <= k;
        addr <= a;
        wdata <= d;
        @(posedge mclk_i);
        req <= 1'b0;
        lat = 0;
        oe = 1'b0;
        for (int i = 0; i < 600 && !(done || err); i++) begin
            @(posedge mclk_i);
            if (lat == 0 && !(&cmd_n)) begin
                lat = i + 1;
                oe = dat_oe;
            end
        end
        chk_val("completion", 20'h1, 20'(done | err));
        chk_val("data drive", 20'(k[2]), 20'(oe));
        fin = done;
        rd = rdata;
    endtask : acc

    // Bus init on power-on and on the reset instruction
    task automatic t_init;
        cyc(3);
        chk_val("init after reset", 20'h1, 20'(init_n));
        cpu_reset <= 1'b1;
        @(posedge mclk_i);
        cpu_reset <= 1'b0;
        @(posedge mclk_i);
        chk_val("init on reset instr", 20'h0, 20'(init_n));
        cyc(2);
        chk_val("init released", 20'h1, 20'(init_n));
    endtask : t_init

    // Words in both spaces, both directions, prompt and slow answers
    task automatic t_spaces;
        logic [15:0] rd;
        logic        fin;
        int          lat;
        logic [19:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? 20'h8c6e2 : 20'hf5a3c;
            dly <= i ? 4'h9 : 4'h0;
            acc({1'b1, i[0], 1'b0}, a, 16'h3c5a ^ 16'(i), rd, fin, lat);
            if (i == 0) lat_hold = lat;
            chk_val("write strobe", i ? 20'h7 : 20'hd, 20'(seen_cmd));
            chk_val("bus address", a, seen_adr);
            acc({1'b0, i[0], 1'b0}, a, 16'h0000, rd, fin, lat);
            chk_val("read strobe", i ? 20'hb : 20'he, 20'(seen_cmd));
            chk_val("read data", 20'(16'h3c5a ^ 16'(i)), 20'(rd));
        end
        dly <= 4'h0;
    endtask : t_spaces

    // Even byte on D15..D8, odd byte on D7..D0
    task automatic t_lanes;
        logic [15:0] rd;
        logic        fin;
        int          lat;
        acc(3'b101, 20'h00010, 16'h005a, rd, fin, lat);
        acc(3'b000, 20'h00010, 16'h0000, rd, fin, lat);
        chk_val("even lane write", 20'h05a00, 20'(rd));
        acc(3'b101, 20'h00013, 16'h005a, rd, fin, lat);
        acc(3'b000, 20'h00012, 16'h0000, rd, fin, lat);
        chk_val("odd lane write", 20'h0005a, 20'(rd));
        acc(3'b100, 20'h00014, 16'hc3a5, rd, fin, lat);
        acc(3'b001, 20'h00014, 16'h0000, rd, fin, lat);
        chk_val("even lane read", 20'h000c3, 20'(rd));
        acc(3'b001, 20'h00015, 16'h0000, rd, fin, lat);
        chk_val("odd lane read", 20'h000a5, 20'(rd));
    endtask : t_lanes

    // Hold mode keeps the bus, then yields to a common request
    task automatic t_hold;
        int off;
        off = 0;
        cyc(20);
        chk_val("bus kept", 20'h1, 20'(busy_oe));
        chk_val("busy driven", 20'h0, 20'(busy_w));
        cbrq_n <= 1'b0;
        cyc(8);
        chk_val("bus yielded", 20'h0, 20'(busy_oe));
        req <= 1'b1;
        {we, io, byte_acc} <= 3'b000;
        for (int i = 0; i < 60 && !done; i++) begin
            @(posedge mclk_i);
            if (!busy_oe) off++;
            if (!(&cmd_n)) req <= 1'b0;
        end
        cbrq_n <= 1'b1;
        chk_val("access after yield", 20'h1, 20'(done));
        chk_val("off bus after request", 20'h1, 20'(off >= 1));
    endtask : t_hold

    // Release mode: bus given up per cycle, three more wait states
    task automatic t_release;
        logic [15:0] rd;
        logic        fin;
        int          lat;
        cfg_release <= 1'b1;
        acc(3'b100, 20'h00020, 16'h1111, rd, fin, lat);
        chk_val("bus given up", 20'h0, 20'(busy_oe));
        fork
            acc(3'b100, 20'h00020, 16'h2222, rd, fin, lat);
            begin
                cyc(6);
                cfg_release <= 1'b0;
            end
        join
        chk_val("wait states", 20'(lat_hold + 3), 20'(lat));
        chk_val("request dropped", 20'h1, 20'(breq_n));
    endtask : t_release

    // Timer phase timeout while acquiring, backstop counter timeout with a silent peripheral
    task automatic t_timeout;
        logic [15:0] rd;
        logic        fin;
        int          lat;
        int          e0;
        int          d0;
        other_busy_n <= 1'b0;
        cyc(4);
        e0 = n_err;
        d0 = n_done;
        req <= 1'b1;
        {we, io, byte_acc} <= 3'b000;
        @(posedge mclk_i);
        req <= 1'b0;
        cyc(6);
        tmr1 <= 1'b1;
        cyc(2);
        tmr1 <= 1'b0;
        cyc(20);
        chk_val("no error before tmr3", 20'(e0), 20'(n_err));
        tmr3 <= 1'b1;
        cyc(2);
        tmr3 <= 1'b0;
        cyc(10);
        chk_val("error while acquiring", 20'(e0 + 1), 20'(n_err));
        chk_val("no completion", 20'(d0), 20'(n_done));
        other_busy_n <= 1'b1;
        acc(3'b100, 20'h00024, 16'h4242, rd, fin, lat);
        tmr1 <= 1'b1;
        cyc(2);
        tmr1 <= 1'b0;
        tmr3 <= 1'b1;
        cyc(2);
        tmr3 <= 1'b0;
        cyc(10);
        chk_val("no error after ack", 20'(e0 + 1), 20'(n_err));
        mute <= 1'b1;
        acc(3'b000, 20'h00024, 16'h0000, rd, fin, lat);
        chk_val("backstop error", 20'h0, 20'(fin));
        chk_val("strobes off", 20'hf, 20'(cmd_n));
        mute <= 1'b0;
    endtask : t_timeout

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk_i);
        chk_val("init in reset", 20'h0, 20'(init_n));
        rst_i <= 1'b0;
        t_init;
        t_spaces;
        t_lanes;
        t_hold;
        t_release;
        t_timeout;
        conclude;
    end

    // Watchdog for a hung run
    initial begin
        #200us;
        n_errors++;
        conclude;
    end
endmodule : sbmi_port_test

`default_nettype wire
